// File: hdl/sos_params.svh
// Offsets, field positions, reset values for the status output selector
`ifndef SOS_PARAMS_SVH
`define SOS_PARAMS_SVH
`define SOS_ADDR_W          8
`define SOS_REG_FB_RUN      8'h01
`define SOS_REG_FB_FREF     8'h02
`define SOS_REG_CTRL        8'h10
`define SOS_REG_SEL         8'h11
`define SOS_REG_ANALOG      8'h12
`define SOS_REG_STATUS      8'h20
`define SOS_REG_FREF_OUT    8'h21
`define SOS_SEL_BUS_LSB     0
`define SOS_SEL_FIRST_LSB   8
`define SOS_SEL_SECOND_LSB  16
`define SOS_RST_SEL_BUS     5'h02
`define SOS_RST_SEL_FIRST   5'h01
`define SOS_RST_SEL_SECOND  5'h00
`define SOS_RST_ANALOG_SEL  3'h0
`endif

// File: hdl/sos_pkg.sv
// Types for the status output selector
package sos_pkg;
  typedef logic [4:0]  sos_sel_t;
  typedef logic [15:0] sos_freq_t;
  typedef struct packed {
    logic fault;
    logic run_fwd;
    logic run_rev;
    logic voltage_out;
    logic freq_agree;
    logic overtorque;
    logic low_torque;
    logic alarm;
    logic output_blocked;
    logic ready;
    logic retrying;
    logic undervoltage_flag;
    logic reverse_running;
    logic speed_search;
    logic feedback_lost;
  } sos_drive_s;
  typedef struct packed {
    logic      fwd;
    logic      rev;
    sos_freq_t fref;
  } sos_cmd_s;
endpackage : sos_pkg

// File: hdl/sos_status_output_selector.sv
// Command source routing and multi-function status output mapping
// Operation
// - Select input closed: run and reference come from bus words 0001H, 0002H.
// - Select input open: use local/remote source, ignore bus command words.
// - Three status outputs, each chosen by its own function select.
// - Selection 0 closes output while drive is faulted.
// - Selection 1 closes on forward/reverse run command or voltage output.
// - Selection 2 closes when output frequency agrees with commanded frequency.
// - Selection 3 closes while output frequency below minimum output frequency.
// - Selection 4 closes at or above detection level; 5 at or below.
// - Selections 6/7 overtorque NO/NC; 8/9 low torque NO/NC.
// - Selection 10 closes while any alarm is detected.
// - Selection 11 closes while drive output is blocked.
// - Selection 12 closes while local operation is selected.
// - Selection 13 closes when no fault and drive is ready.
// - Selection 14 closes while fault retries are in progress.
// - Selection 15 closes while undervoltage is detected.
// - Selection 16 closes while running in reverse.
// - Selection 17 closes during speed search.
// - Selection 19 closes during feedback loss indication.
// - Bus-only output has no terminal; reported only in bus status.
// - Analog select 1 with step reference 2 uses auxiliary analog reference.
// - Analog select 0 disables analog input; 2 and 3 do nothing.
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "sos_params.svh"
module sos_status_output_selector
  import sos_pkg::*;
(
  // Clock and reset
  input  wire logic                   mclk_in,
  input  wire logic                   rst_n_in,
  // Register port
  input  wire logic [`SOS_ADDR_W-1:0] addr_in,
  input  wire logic [31:0]            wdata_in,
  input  wire logic                   wr_in,
  input  wire logic                   rd_in,
  output logic      [31:0]            rdata_out,
  // Source selection
  input  wire logic                   cmd_source_sel_in,
  input  wire logic                   local_sel_in,
  input  wire sos_cmd_s               local_cmd_in,
  input  wire sos_cmd_s               remote_cmd_in,
  input  wire logic [1:0]             step_sel_in,
  input  wire sos_freq_t              second_step_frequency_in,
  input  wire sos_freq_t              auxiliary_frequency_reference_in,
  // Drive state
  input  wire sos_drive_s             drive_in,
  input  wire sos_freq_t              output_freq_in,
  input  wire sos_freq_t              min_output_freq_in,
  // Results
  output sos_cmd_s                    active_cmd_out,
  output logic                        aux_ref_active_out,
  output logic                        first_status_output_out,
  output logic                        second_status_output_out
);

  // Software-held settings and registered status outputs
  logic [15:0] fb_run_word;
  sos_freq_t   fb_fref_word;
  sos_freq_t   frequency_detection_level;
  sos_sel_t    bus_only_output_function_sel;
  sos_sel_t    first_terminal_output_function_sel;
  sos_sel_t    second_terminal_output_function_sel;
  logic [2:0]  analog_input_function_sel;
  logic        bus_only_status_output;
  logic        first_status_output;
  logic        second_status_output;

  // Status condition for one function select
  function automatic logic sos_cond(input sos_sel_t sel, input sos_drive_s d,
                                    input logic agree, input logic zero,
                                    input logic ge, input logic le,
                                    input logic is_local);
    logic r;
    r = 1'b0;
    case (sel)
      5'h00: r = d.fault;
      5'h01: r = d.run_fwd | d.run_rev | d.voltage_out;
      5'h02: r = agree;
      5'h03: r = zero;
      5'h04: r = ge;
      5'h05: r = le;
      5'h06: r = d.overtorque;
      5'h07: r = ~d.overtorque;
      5'h08: r = d.low_torque;
      5'h09: r = ~d.low_torque;
      5'h0a: r = d.alarm;
      5'h0b: r = d.output_blocked;
      5'h0c: r = is_local;
      5'h0d: r = ~d.fault & d.ready;
      5'h0e: r = d.retrying;
      5'h0f: r = d.undervoltage_flag;
      5'h10: r = d.reverse_running;
      5'h11: r = d.speed_search;
      5'h13: r = d.feedback_lost;
      // Unlisted selections leave the contact open
      default: r = 1'b0;
    endcase
    return r;
  endfunction : sos_cond

  // Comparisons shared by all three outputs
  wire logic freq_agree = drive_in.freq_agree;
  wire logic zero_speed = output_freq_in < min_output_freq_in;
  wire logic freq_ge    = output_freq_in >= frequency_detection_level;
  wire logic freq_le    = output_freq_in <= frequency_detection_level;

  wire logic next_bus_out    = sos_cond(bus_only_output_function_sel, drive_in,
                               freq_agree, zero_speed, freq_ge, freq_le,
                               local_sel_in);
  wire logic next_first_out  = sos_cond(first_terminal_output_function_sel, drive_in,
                               freq_agree, zero_speed, freq_ge, freq_le,
                               local_sel_in);
  wire logic next_second_out = sos_cond(second_terminal_output_function_sel, drive_in,
                               freq_agree, zero_speed, freq_ge, freq_le,
                               local_sel_in);

  // Source routing
  wire sos_cmd_s  fb_cmd       = '{fwd: fb_run_word[0], rev: fb_run_word[1],
                                   fref: fb_fref_word};
  wire sos_cmd_s  lr_cmd       = local_sel_in ? local_cmd_in : remote_cmd_in;
  wire sos_cmd_s  routed_cmd   = cmd_source_sel_in ? fb_cmd : lr_cmd;
  // Only selection 1 uses the analog input; 0, 2, 3 leave the step reference
  wire logic      aux_use      = (analog_input_function_sel == 3'h1) &&
                                 (step_sel_in == 2'h1);
  wire sos_freq_t step_fref    = aux_use ? auxiliary_frequency_reference_in
                                         : second_step_frequency_in;
  wire logic      step2_sel    = step_sel_in == 2'h1;
  wire sos_cmd_s  next_cmd     = '{fwd: routed_cmd.fwd, rev: routed_cmd.rev,
                                   fref: step2_sel ? step_fref : routed_cmd.fref};

  // Register decode
  wire logic wr_run   = wr_in && addr_in == `SOS_REG_FB_RUN;
  wire logic wr_fref  = wr_in && addr_in == `SOS_REG_FB_FREF;
  wire logic wr_ctrl  = wr_in && addr_in == `SOS_REG_CTRL;
  wire logic wr_sel   = wr_in && addr_in == `SOS_REG_SEL;
  wire logic wr_anlg  = wr_in && addr_in == `SOS_REG_ANALOG;

  logic [31:0] rd_mux;
  always_comb begin
    unique case (addr_in)
      `SOS_REG_FB_RUN:   rd_mux = {16'h0000, fb_run_word};
      `SOS_REG_FB_FREF:  rd_mux = {16'h0000, fb_fref_word};
      `SOS_REG_CTRL:     rd_mux = {16'h0000, frequency_detection_level};
      `SOS_REG_SEL:      rd_mux = {11'h000, second_terminal_output_function_sel,
                                   3'h0, first_terminal_output_function_sel,
                                   3'h0, bus_only_output_function_sel};
      `SOS_REG_ANALOG:   rd_mux = {29'h0000000, analog_input_function_sel};
      // Bus-only output is visible nowhere else
      `SOS_REG_STATUS:   rd_mux = {28'h0000000, aux_ref_active_out, second_status_output,
                                   first_status_output, bus_only_status_output};
      `SOS_REG_FREF_OUT: rd_mux = {16'h0000, active_cmd_out.fref};
      default:           rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fb_run_word                         <= 16'h0000;
      fb_fref_word                        <= 16'h0000;
      frequency_detection_level           <= 16'h0000;
      bus_only_output_function_sel        <= `SOS_RST_SEL_BUS;
      first_terminal_output_function_sel  <= `SOS_RST_SEL_FIRST;
      second_terminal_output_function_sel <= `SOS_RST_SEL_SECOND;
      analog_input_function_sel           <= `SOS_RST_ANALOG_SEL;
    end else begin
      if (wr_run)  fb_run_word               <= wdata_in[15:0];
      if (wr_fref) fb_fref_word              <= wdata_in[15:0];
      if (wr_ctrl) frequency_detection_level <= wdata_in[15:0];
      if (wr_sel) begin
        bus_only_output_function_sel        <= wdata_in[`SOS_SEL_BUS_LSB +: 5];
        first_terminal_output_function_sel  <= wdata_in[`SOS_SEL_FIRST_LSB +: 5];
        second_terminal_output_function_sel <= wdata_in[`SOS_SEL_SECOND_LSB +: 5];
      end
      if (wr_anlg) analog_input_function_sel <= wdata_in[2:0];
    end
  end

  // Outputs re-evaluated every cycle
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_only_status_output <= 1'b0;
      first_status_output    <= 1'b0;
      second_status_output   <= 1'b0;
      active_cmd_out         <= '0;
      aux_ref_active_out     <= 1'b0;
      rdata_out              <= 32'h00000000;
    end else begin
      bus_only_status_output <= next_bus_out;
      first_status_output    <= next_first_out;
      second_status_output   <= next_second_out;
      active_cmd_out         <= next_cmd;
      aux_ref_active_out     <= aux_use;
      rdata_out              <= rd_in ? rd_mux : 32'h00000000;
    end
  end

  assign first_status_output_out  = first_status_output;
  assign second_status_output_out = second_status_output;

endmodule : sos_status_output_selector
`default_nettype wire

// File: verif/sos_far_side.sv
// Far-side model: operator panel, remote terminals and analog sources
`timescale 1ns/1ps
`default_nettype none
module sos_far_side
  import sos_pkg::*;
(
  // Command sources
  output sos_cmd_s  local_cmd_out,
  output sos_cmd_s  remote_cmd_out,
  // Stored and analog references
  output sos_freq_t second_step_out,
  output sos_freq_t aux_ref_out
);
  // Distinct patterns so a wrong route never matches by chance
  assign local_cmd_out   = '{fwd: 1'b0, rev: 1'b1, fref: 16'h0a5a};
  assign remote_cmd_out  = '{fwd: 1'b1, rev: 1'b1, fref: 16'h3c3c};
  assign second_step_out = 16'h0777;
  assign aux_ref_out     = 16'h0999;
endmodule : sos_far_side
`default_nettype wire

// File: verif/sos_status_output_selector_bench.sv
// Self-checking bench for the status output selector
`timescale 1ns/1ps
`default_nettype none
`include "sos_params.svh"
module sos_status_output_selector_bench
  import sos_pkg::*;
;
  logic        mclk_in, rst_n_in, wr_in, rd_in, cmd_source_sel_in, local_sel_in;
  logic [7:0]  addr_in;
  logic [31:0] wdata_in, rdata_out, got;
  logic [1:0]  step_sel_in;
  sos_cmd_s    lc, rc, active_cmd_out;
  sos_freq_t   ss, aux, output_freq_in, min_output_freq_in;
  sos_drive_s  drive_in;
  logic        aux_ref_active_out, first_status_output_out, second_status_output_out;
  int          errors = 0;
  int          tests_run = 0;
  // Expected closure per code: all drive flags set, then only ready set
  logic [20:0] tab [2] = '{21'h0bdd7f, 21'h002290};
  sos_far_side i_far (.local_cmd_out(lc), .remote_cmd_out(rc), .second_step_out(ss),
    .aux_ref_out(aux));
  sos_status_output_selector i_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .cmd_source_sel_in(cmd_source_sel_in), .local_sel_in(local_sel_in), .local_cmd_in(lc),
    .remote_cmd_in(rc), .step_sel_in(step_sel_in), .second_step_frequency_in(ss),
    .auxiliary_frequency_reference_in(aux), .drive_in(drive_in),
    .output_freq_in(output_freq_in), .min_output_freq_in(min_output_freq_in),
    .active_cmd_out(active_cmd_out), .aux_ref_active_out(aux_ref_active_out),
    .first_status_output_out(first_status_output_out),
    .second_status_output_out(second_status_output_out));
  always #10 mclk_in = ~mclk_in;
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    @(posedge mclk_in);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    @(posedge mclk_in);
    // Data stand only until this edge replaces them
    d = rdata_out;
  endtask : rd
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  initial begin
    #100000 errors++;
    report_and_stop();
  end
  initial begin
    {mclk_in, rst_n_in, wr_in, rd_in, cmd_source_sel_in, local_sel_in} = '0;
    {addr_in, wdata_in, step_sel_in, drive_in, output_freq_in, min_output_freq_in} = '0;
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    rd(`SOS_REG_SEL, got);
    chk(got, 32'h0000_0102);
    rd(8'h30, got);
    chk(got, 32'h0);
    wr(`SOS_REG_FB_RUN, 32'h1);
    wr(`SOS_REG_FB_FREF, 32'h1234);
    rd(`SOS_REG_FB_RUN, got);
    chk(got, 32'h1);
    for (int i = 0; i < 3; i++) begin
      cmd_source_sel_in <= (i == 0);
      local_sel_in <= (i == 1);
      repeat (2) @(posedge mclk_in);
      chk({14'h0, active_cmd_out},
          {14'h0, i == 0 ? 18'h21234 : i == 1 ? lc : rc});
    end
    rd(`SOS_REG_FREF_OUT, got);
    chk(got, {16'h0, rc.fref});
    step_sel_in <= 2'h1;
    for (int a = 0; a < 5; a++) begin
      wr(`SOS_REG_ANALOG, a);
      @(posedge mclk_in);
      chk({aux_ref_active_out, active_cmd_out.fref},
          a == 1 ? {1'b1, aux} : {1'b0, ss});
    end
    step_sel_in <= 2'h0;
    wr(`SOS_REG_CTRL, 32'h5);
    rd(`SOS_REG_CTRL, got);
    chk(got, 32'h5);
    min_output_freq_in <= 16'h000a;
    for (int p = 0; p < 2; p++) begin
      // Second pattern sets only the ready flag
      drive_in <= p ? 15'h0020 : 15'h7fff;
      output_freq_in <= p ? 16'h0014 : 16'h0005;
      local_sel_in <= !p;
      for (int s = 0; s < 21; s++) begin
        wr(`SOS_REG_SEL, {11'h0, s[4:0], 3'h0, s[4:0], 3'h0, s[4:0]});
        repeat (2) @(posedge mclk_in);
        rd(`SOS_REG_STATUS, got);
        chk(got[3:0], {1'b0, {3{tab[p][s]}}});
        chk(second_status_output_out, tab[p][s]);
        chk(first_status_output_out, tab[p][s]);
      end
    end
    // Normally closed overtorque contact must open on the event
    wr(`SOS_REG_SEL, 32'h0007_0707);
    @(posedge mclk_in);
    chk(first_status_output_out, 1'b1);
    drive_in <= 15'h0220;
    repeat (2) @(posedge mclk_in);
    chk(first_status_output_out, 1'b0);
    chk(second_status_output_out, 1'b0);
    report_and_stop();
  end
endmodule : sos_status_output_selector_bench
`default_nettype wire

// File: verif/sos_status_output_selector_sva.sv
// Assertions for the status output selector
`timescale 1ns/1ps
`default_nettype none
`include "sos_params.svh"
module sos_status_output_selector_sva
  import sos_pkg::*;
(
  // Clock, reset, register port
  input wire logic [0:0]             mclk_in,
  input wire logic                   rst_n_in,
  input wire logic [`SOS_ADDR_W-1:0] addr_in,
  input wire logic [31:0]            wdata_in,
  input wire logic                   wr_in,
  // Sources and drive state
  input wire logic                   cmd_source_sel_in,
  input wire logic                   local_sel_in,
  input wire sos_cmd_s               local_cmd_in,
  input wire sos_cmd_s               remote_cmd_in,
  input wire logic [1:0]             step_sel_in,
  input wire sos_freq_t              auxiliary_frequency_reference_in,
  input wire sos_drive_s             drive_in,
  input wire sos_freq_t              output_freq_in,
  input wire sos_freq_t              min_output_freq_in,
  // Results
  input wire sos_cmd_s               active_cmd_out,
  input wire logic                   aux_ref_active_out,
  input wire logic                   first_status_output_out,
  input wire logic                   second_status_output_out
);
  logic [4:0]  sel1;
  logic [4:0]  sel2;
  logic [2:0]  ana;
  sos_freq_t   lvl;
  sos_cmd_s    fb;
  logic [31:0] cond;
  // Condition per selection code; 18 and 20 up stay open
  assign cond = {12'h000, drive_in.feedback_lost, 1'b0, drive_in.speed_search,
    drive_in.reverse_running, drive_in.undervoltage_flag, drive_in.retrying,
    !drive_in.fault && drive_in.ready, local_sel_in, drive_in.output_blocked,
    drive_in.alarm, !drive_in.low_torque, drive_in.low_torque, !drive_in.overtorque,
    drive_in.overtorque, output_freq_in <= lvl, output_freq_in >= lvl,
    output_freq_in < min_output_freq_in, drive_in.freq_agree,
    drive_in.run_fwd | drive_in.run_rev | drive_in.voltage_out, drive_in.fault};
  // Shadow of the writable settings other than the bus-only function select
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sel1 <= `SOS_RST_SEL_FIRST;
      sel2 <= `SOS_RST_SEL_SECOND;
      ana  <= `SOS_RST_ANALOG_SEL;
      lvl  <= '0;
      fb   <= '0;
    end else if (wr_in) begin
      case (addr_in)
        `SOS_REG_SEL: begin
          sel1 <= wdata_in[12:8];
          sel2 <= wdata_in[20:16];
        end
        `SOS_REG_ANALOG: ana <= wdata_in[2:0];
        `SOS_REG_CTRL: lvl <= wdata_in[15:0];
        `SOS_REG_FB_RUN: {fb.fwd, fb.rev} <= {wdata_in[0], wdata_in[1]};
        `SOS_REG_FB_FREF: fb.fref <= wdata_in[15:0];
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  AST_FIRST_MAP: assert property (
    1'b1 |=> first_status_output_out == $past(cond[sel1]))
    else $error("first output differs from selected condition");
  AST_SECOND_MAP: assert property (
    1'b1 |=> second_status_output_out == $past(cond[sel2]))
    else $error("second output differs from selected condition");
  AST_UNUSED_SEL: assert property (
    (sel2 >= 5'h14) [*2] |=> !second_status_output_out)
    else $error("unused selection closed the output");
  AST_NC_EDGE: assert property (
    sel1 == 5'h07 && $stable(sel1) && $rose(drive_in.overtorque)
    |=> $fell(first_status_output_out))
    else $error("normally closed output did not open");
  AST_BUS_ROUTE: assert property (
    cmd_source_sel_in && step_sel_in != 2'h1 |=> active_cmd_out == $past(fb))
    else $error("bus words not routed");
  // Source choice is the one seen at the launching edge
  AST_LOCAL_ROUTE: assert property (!cmd_source_sel_in && step_sel_in != 2'h1
    |=> active_cmd_out == ($past(local_sel_in) ? $past(local_cmd_in) : $past(remote_cmd_in)))
    else $error("local or remote source not routed");
  AST_AUX_REF: assert property (ana == 3'h1 && step_sel_in == 2'h1
    |=> aux_ref_active_out && active_cmd_out.fref == $past(auxiliary_frequency_reference_in))
    else $error("auxiliary reference not used");
  AST_AUX_IDLE: assert property (ana != 3'h1 |=> !aux_ref_active_out)
    else $error("analog input active while not selected");
endmodule : sos_status_output_selector_sva
bind sos_status_output_selector sos_status_output_selector_sva i_sva (.mclk_in(mclk_in),
  .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .cmd_source_sel_in(cmd_source_sel_in), .local_sel_in(local_sel_in),
  .local_cmd_in(local_cmd_in), .remote_cmd_in(remote_cmd_in), .step_sel_in(step_sel_in),
  .auxiliary_frequency_reference_in(auxiliary_frequency_reference_in), .drive_in(drive_in),
  .output_freq_in(output_freq_in), .min_output_freq_in(min_output_freq_in),
  .active_cmd_out(active_cmd_out), .aux_ref_active_out(aux_ref_active_out),
  .first_status_output_out(first_status_output_out),
  .second_status_output_out(second_status_output_out));
`default_nettype wire
